// [rtl/gpio_port_pkg.sv]
/*
  Constants shared by the eight-bit I/O port and its interrupt detector:
  register byte offsets, reset values and sensitivity codes.
  Assumes a 32-bit Avalon-MM slave with byte addressing and word-aligned registers.
*/
package gpio_port_pkg;

  // Register byte offsets
  localparam logic [4:0] OFS_DATA = 5'h00;
  localparam logic [4:0] OFS_DIR  = 5'h04;
  localparam logic [4:0] OFS_OPT  = 5'h08;
  localparam logic [4:0] OFS_SENS = 5'h0c;
  localparam logic [4:0] OFS_PEND = 5'h10;
  localparam logic [4:0] OFS_PIN  = 5'h14;

  // Reset values
  localparam logic [7:0]  RST_DATA = 8'h00;
  localparam logic [7:0]  RST_DIR  = 8'h00;
  localparam logic [7:0]  RST_OPT  = 8'h00;
  localparam logic [15:0] RST_SENS = 16'h0000;

  // Per-pin sensitivity codes, two bits per pin
  typedef logic [1:0] sens_t;
  localparam sens_t SENS_FALL_LOW = 2'h0;
  localparam sens_t SENS_RISE     = 2'h1;
  localparam sens_t SENS_FALL     = 2'h2;
  localparam sens_t SENS_BOTH     = 2'h3;

endpackage

// [rtl/irq_grp_if.sv]
/*
  Carrier between the port top and its external interrupt detector.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface irq_grp_if #(parameter int WIDTH = 8);
  logic [WIDTH-1:0]   pin_lvl;   // Sampled pin levels
  logic [WIDTH-1:0]   armed;     // Pins in interrupt input mode
  logic [2*WIDTH-1:0] sens;      // Two sensitivity bits per pin
  logic               sens_chg;  // Pulse: sensitivity value changed
  logic               vec_fetch; // Pulse: vector fetched
  logic               pend;      // Request latch

  modport port_side (output pin_lvl, armed, sens, sens_chg, vec_fetch, input pend);
  modport det_side  (input pin_lvl, armed, sens, sens_chg, vec_fetch, output pend);
endinterface

// [rtl/irq_grp_detect.sv]
/*
  Edge or level detection per pin, OR of all pins, and the hidden request latch.
  Assumes pin levels are already synchronous to core_clk.
*/
`timescale 1ns/10ps
module irq_grp_detect #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic  core_clk,
  input  wire logic  arst_n,
  // Port side
  irq_grp_if.det_side grp
);

  logic [WIDTH-1:0] prev_ff;
  logic [WIDTH-1:0] hit;
  logic             any_hit;
  logic             pend_ff;
  logic             nxt_pend;

  // Per-pin event by its own sensitivity code
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_pin
    wire gpio_port_pkg::sens_t code = grp.sens[2*i +: 2];
    wire rise = ~prev_ff[i] & grp.pin_lvl[i];
    wire fall = prev_ff[i] & ~grp.pin_lvl[i];
    assign hit[i] = grp.armed[i] &
                    (((code == gpio_port_pkg::SENS_FALL_LOW) & ~grp.pin_lvl[i]) |
                     ((code == gpio_port_pkg::SENS_RISE) & rise) |
                     ((code == gpio_port_pkg::SENS_FALL) & fall) |
                     ((code == gpio_port_pkg::SENS_BOTH) & (rise | fall)));
  end

  // Detected first, then ORed into one vector request
  assign any_hit  = |hit;
  // New event beats a clear in the same cycle
  assign nxt_pend = any_hit | (pend_ff & ~(grp.vec_fetch | grp.sens_chg));
  assign grp.pend = pend_ff;

  // Previous levels and latch
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prev_ff <= '0;
      pend_ff <= 1'b0;
    end
    else
    begin
      prev_ff <= grp.pin_lvl;
      pend_ff <= nxt_pend;
    end
  end

  a_fetch_clears: assert property (@(posedge core_clk) disable iff (!arst_n)
    (grp.vec_fetch && !any_hit) |=> !pend_ff)
    else $error("request latch not cleared by vector fetch");

  a_sens_clears: assert property (@(posedge core_clk) disable iff (!arst_n)
    (grp.sens_chg && !any_hit) |=> !pend_ff)
    else $error("request latch not cleared by sensitivity change");

  a_event_sets: assert property (@(posedge core_clk) disable iff (!arst_n)
    (|(grp.armed & ~grp.pin_lvl) && grp.sens == '0) |=> pend_ff)
    else $error("low level on armed pin did not set request");

endmodule

// [rtl/gpio_port.sv]
/*
  Eight-bit general purpose I/O port with external interrupt, alternate
  function override and an Avalon-MM register slave with waitrequest.
  Assumes pin and peripheral inputs are synchronous to core_clk and that the
  pad ring resolves pin level from drive value, enable and pull-up.
*/
// The Avalon-MM register port and the register addresses were decided locally.
// Notes on behaviour
// - Up to eight pins; bit n of the data, direction and option registers controls pin n.
// - Input pin: data register read returns the present pin level.
// - Writing data while input only changes the latch, not the pin.
// - Output pin: driven from latch; data read returns the latch value.
// - Option picks push-pull or open-drain; open-drain one floats, zero drives low.
// - Interrupt input raises request on event chosen by per-pin sensitivity.
// - Events of all pins detected separately then ORed into one request.
// - Request latch hidden from software; cleared when vector is fetched.
// - Changing sensitivity bits to a new value clears any pending request of the group.
// - Interrupt delivered only in interrupt input mode and with mask inactive.
// - Peripheral claiming a pin overrides normal port programming.
// - Peripheral output makes pin an output, push-pull or open-drain as asked.
// - Peripheral input on an input pin: level still readable in data register.
// - Input pin with enabled peripheral output reads back that output value.
// - Output pin with peripheral input feeds the latch value to the peripheral.
// - Low-power modes leave configuration alone; external interrupts wake the device.
`timescale 1ns/10ps
module gpio_port #(
  parameter int               WIDTH    = 8,
  parameter logic [WIDTH-1:0] IRQ_PINS = 8'hff
) (
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               arst_n,
  // Avalon-MM slave
  input  wire logic [4:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic      [31:0]        avs_readdata,
  output logic                    avs_waitrequest,
  // Pins
  input  wire logic [WIDTH-1:0]   pin_in,
  output logic      [WIDTH-1:0]   pin_out,
  output logic      [WIDTH-1:0]   pin_oe_n,
  output logic      [WIDTH-1:0]   pin_pullup_en,
  // Alternate functions of on-chip peripherals
  input  wire logic [WIDTH-1:0]   af_out_en,
  input  wire logic [WIDTH-1:0]   af_out,
  input  wire logic [WIDTH-1:0]   af_open_drain,
  input  wire logic [WIDTH-1:0]   af_in_en,
  output logic      [WIDTH-1:0]   af_in,
  // Processor side
  input  wire logic               cpu_irq_mask,
  input  wire logic               vector_fetch,
  output logic                    ext_irq_req,
  output logic                    wake_req
);

  // Registers
  logic [WIDTH-1:0]   pin_data_latch_ff;
  logic [WIDTH-1:0]   dir_ff;
  logic [WIDTH-1:0]   opt_ff;
  logic [2*WIDTH-1:0] ext_irq_sensitivity_reg_ff;
  logic               waitreq_ff;
  logic [31:0]        readdata_ff;
  logic [WIDTH-1:0]   pin_out_ff;
  logic [WIDTH-1:0]   pin_oe_n_ff;
  logic [WIDTH-1:0]   pullup_ff;
  logic [WIDTH-1:0]   af_in_ff;
  logic               irq_req_ff;
  logic               wake_ff;

  irq_grp_if #(.WIDTH(WIDTH)) grp ();

  // Bus decode
  wire        req       = avs_read | avs_write;
  wire        accept    = req & ~waitreq_ff;
  wire [4:0]  word_addr = {avs_address[4:2], 2'b00};
  wire        hit_data  = word_addr == gpio_port_pkg::OFS_DATA;
  wire        hit_dir   = word_addr == gpio_port_pkg::OFS_DIR;
  wire        hit_opt   = word_addr == gpio_port_pkg::OFS_OPT;
  wire        hit_sens  = word_addr == gpio_port_pkg::OFS_SENS;
  wire        hit_pend  = word_addr == gpio_port_pkg::OFS_PEND;
  wire        hit_pin   = word_addr == gpio_port_pkg::OFS_PIN;
  wire        wr_acc    = accept & avs_write;
  wire        wr_lane0  = wr_acc & avs_byteenable[0];
  wire        wr_lane1  = wr_acc & avs_byteenable[1];

  // Write next values; only the low byte lanes hold bits
  wire [WIDTH-1:0] wdata = avs_writedata[WIDTH-1:0];
  wire [WIDTH-1:0] nxt_data = (wr_lane0 & hit_data) ? wdata : pin_data_latch_ff;
  wire [WIDTH-1:0] nxt_dir  = (wr_lane0 & hit_dir) ? wdata : dir_ff;
  wire [WIDTH-1:0] nxt_opt  = (wr_lane0 & hit_opt) ? wdata : opt_ff;
  wire [15:0]      sens_wide = {{(16-2*WIDTH){1'b0}}, ext_irq_sensitivity_reg_ff};
  wire [15:0]      nxt_sens_wide = {(wr_lane1 & hit_sens) ? avs_writedata[15:8]
                                                          : sens_wide[15:8],
                                    (wr_lane0 & hit_sens) ? avs_writedata[7:0]
                                                          : sens_wide[7:0]};
  wire [2*WIDTH-1:0] nxt_sens = nxt_sens_wide[2*WIDTH-1:0];
  // Only a real change of sensitivity discards a pending request
  wire        sens_chg  = nxt_sens != ext_irq_sensitivity_reg_ff;

  // Mode decode per pin
  wire [WIDTH-1:0] is_out    = dir_ff;
  wire [WIDTH-1:0] in_pullup = ~dir_ff & opt_ff;
  wire [WIDTH-1:0] out_pp    = dir_ff & opt_ff;

  // Effective drive: a peripheral output wins over port programming
  wire [WIDTH-1:0] drv_en  = af_out_en | is_out;
  wire [WIDTH-1:0] drv_val = (af_out_en & af_out) |
                             (~af_out_en & pin_data_latch_ff);
  wire [WIDTH-1:0] drv_pp  = (af_out_en & ~af_open_drain) |
                             (~af_out_en & out_pp);
  // Drive when push-pull, or when open-drain and pulling low
  wire [WIDTH-1:0] nxt_oe_n   = ~(drv_en & (drv_pp | ~drv_val));
  wire [WIDTH-1:0] nxt_pin    = drv_val & drv_pp;
  wire [WIDTH-1:0] nxt_pullup = in_pullup & ~af_out_en;

  // Data register read-back per pin
  wire [WIDTH-1:0] rd_data = (dir_ff & pin_data_latch_ff) |
                             (~dir_ff & af_out_en & af_out) |
                             (~dir_ff & ~af_out_en & pin_in);

  // Level presented to peripheral inputs
  wire [WIDTH-1:0] nxt_af_in = ((dir_ff & pin_data_latch_ff) |
                                (~dir_ff & pin_in)) & af_in_en;

  // Read mux; unmapped offsets read as zero, and so does the request latch,
  // which software never sees: only a fetch or a sensitivity change clears it
  wire [31:0] rd_mux =
      hit_data ? {{(32-WIDTH){1'b0}}, rd_data} :
      hit_dir  ? {{(32-WIDTH){1'b0}}, dir_ff} :
      hit_opt  ? {{(32-WIDTH){1'b0}}, opt_ff} :
      hit_sens ? {16'h0000, sens_wide} :
      hit_pend ? 32'h00000000 :
      hit_pin  ? {{(32-WIDTH){1'b0}}, pin_in} :
                 32'h00000000;

  // Interrupt arming: direction/option select interrupt input on capable pins
  assign grp.pin_lvl   = pin_in;
  assign grp.armed     = in_pullup & IRQ_PINS & ~af_out_en;
  assign grp.sens      = ext_irq_sensitivity_reg_ff;
  assign grp.sens_chg  = sens_chg;
  assign grp.vec_fetch = vector_fetch;

  // Mask gates delivery but not wake-up
  wire nxt_irq  = grp.pend & ~cpu_irq_mask;
  wire nxt_wake = grp.pend;

  irq_grp_detect #(.WIDTH(WIDTH)) u_detect (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .grp      (grp.det_side)
  );

  // Bus handshake: one wait cycle, so read data is ready when waitrequest drops
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      waitreq_ff  <= 1'b1;
      readdata_ff <= 32'h00000000;
    end
    else
    begin
      waitreq_ff <= ~(req & waitreq_ff);
      if (req & waitreq_ff)
        readdata_ff <= rd_mux;
    end
  end

  // Port configuration; low-power modes have no path into these
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_data_latch_ff          <= gpio_port_pkg::RST_DATA[WIDTH-1:0];
      dir_ff                     <= gpio_port_pkg::RST_DIR[WIDTH-1:0];
      opt_ff                     <= gpio_port_pkg::RST_OPT[WIDTH-1:0];
      ext_irq_sensitivity_reg_ff <= gpio_port_pkg::RST_SENS[2*WIDTH-1:0];
    end
    else
    begin
      pin_data_latch_ff          <= nxt_data;
      dir_ff                     <= nxt_dir;
      opt_ff                     <= nxt_opt;
      ext_irq_sensitivity_reg_ff <= nxt_sens;
    end
  end

  // Pad and peripheral outputs, registered for clean timing
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_out_ff  <= '0;
      pin_oe_n_ff <= '1;
      pullup_ff   <= '0;
      af_in_ff    <= '0;
      irq_req_ff  <= 1'b0;
      wake_ff     <= 1'b0;
    end
    else
    begin
      pin_out_ff  <= nxt_pin;
      pin_oe_n_ff <= nxt_oe_n;
      pullup_ff   <= nxt_pullup;
      af_in_ff    <= nxt_af_in;
      irq_req_ff  <= nxt_irq;
      wake_ff     <= nxt_wake;
    end
  end

  assign avs_readdata    = readdata_ff;
  assign avs_waitrequest = waitreq_ff;
  assign pin_out         = pin_out_ff;
  assign pin_oe_n        = pin_oe_n_ff;
  assign pin_pullup_en   = pullup_ff;
  assign af_in           = af_in_ff;
  assign ext_irq_req     = irq_req_ff;
  assign wake_req        = wake_ff;

  // Read of data register while output returns latch
  a_read_latch: assert property (@(posedge core_clk) disable iff (!arst_n)
    (avs_read && waitreq_ff && hit_data) |=>
      ((avs_readdata[WIDTH-1:0] ^ $past(pin_data_latch_ff)) & $past(dir_ff)) == '0)
    else $error("output pin read did not return latch");

  a_read_pin_level: assert property (@(posedge core_clk) disable iff (!arst_n)
    (avs_read && waitreq_ff && hit_data) |=>
      ((avs_readdata[WIDTH-1:0] ^ $past(pin_in)) & ~$past(dir_ff) & ~$past(af_out_en)) == '0)
    else $error("input pin read did not return pin level");

  a_read_af_out: assert property (@(posedge core_clk) disable iff (!arst_n)
    (avs_read && waitreq_ff && hit_data) |=>
      ((avs_readdata[WIDTH-1:0] ^ $past(af_out)) & ~$past(dir_ff) & $past(af_out_en)) == '0)
    else $error("input pin read did not return peripheral output");

  a_od_float_high: assert property (@(posedge core_clk) disable iff (!arst_n)
    (af_out_en == '0) |=>
      (pin_oe_n & $past(dir_ff & ~opt_ff & ~pin_data_latch_ff)) == '0 &&
      (~pin_oe_n & $past(dir_ff & ~opt_ff & pin_data_latch_ff)) == '0)
    else $error("open-drain drive wrong");

  a_input_released: assert property (@(posedge core_clk) disable iff (!arst_n)
    (af_out_en == '0) |=> (~pin_oe_n & ~$past(dir_ff)) == '0)
    else $error("input pin is being driven");

  a_af_priority: assert property (@(posedge core_clk) disable iff (!arst_n)
    1'b1 |=> (pin_oe_n & $past(af_out_en & ~af_open_drain)) == '0 &&
             ((pin_out ^ $past(af_out)) & $past(af_out_en & ~af_open_drain)) == '0)
    else $error("peripheral push-pull output not on pin");

  a_af_in_latch: assert property (@(posedge core_clk) disable iff (!arst_n)
    1'b1 |=> ((af_in ^ $past(pin_data_latch_ff)) & $past(dir_ff & af_in_en)) == '0)
    else $error("peripheral input not fed from latch");

  a_pullup_mode: assert property (@(posedge core_clk) disable iff (!arst_n)
    1'b1 |=> (pin_pullup_en & ~$past(~dir_ff & opt_ff)) == '0)
    else $error("pull-up enabled outside pull-up mode");

  a_irq_masked: assert property (@(posedge core_clk) disable iff (!arst_n)
    ext_irq_req |-> $past(!cpu_irq_mask) && $past(grp.pend))
    else $error("interrupt delivered while masked");

  a_bus_answer: assert property (@(posedge core_clk) disable iff (!arst_n)
    (req && waitreq_ff) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("waitrequest answer timing wrong");

  // Exactly one wait state per request
  a_one_wait: assert property (@(posedge core_clk) disable iff (!arst_n)
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  // Read data only moves in the wait cycle of a new read or write, one cycle before it is accepted
  a_rdata_held: assert property (@(posedge core_clk) disable iff (!arst_n)
    !(req && waitreq_ff) |=> $stable(avs_readdata))
    else $error("read data changed between reads");

  // Accepted writes land bit for bit
  a_data_write: assert property (@(posedge core_clk) disable iff (!arst_n)
    (wr_lane0 && hit_data) |=> pin_data_latch_ff == $past(avs_writedata[WIDTH-1:0]))
    else $error("data latch write did not land");

  // Bit n of the byte lands in direction bit n
  a_dir_write: assert property (@(posedge core_clk) disable iff (!arst_n)
    (wr_lane0 && hit_dir) |=> dir_ff == $past(avs_writedata[WIDTH-1:0]))
    else $error("direction write did not land");

  // Low-power modes have no way in: only a write moves the setup
  a_config_held: assert property (@(posedge core_clk) disable iff (!arst_n)
    !wr_acc |=> $stable(dir_ff) && $stable(opt_ff) && $stable(pin_data_latch_ff))
    else $error("configuration changed without a write");

  // Push-pull pad copies the latch
  a_pp_drive: assert property (@(posedge core_clk) disable iff (!arst_n)
    (af_out_en == '0) |=>
      ((pin_out ^ $past(pin_data_latch_ff)) & $past(dir_ff & opt_ff)) == '0 &&
      (pin_oe_n & $past(dir_ff & opt_ff)) == '0)
    else $error("push-pull pad not driven from latch");

  // High side only where port or peripheral asks for push-pull
  a_high_side_pp: assert property (@(posedge core_clk) disable iff (!arst_n)
    1'b1 |=> (pin_out & ~pin_oe_n & ~$past((dir_ff & opt_ff & ~af_out_en) |
                                            (af_out_en & ~af_open_drain))) == '0)
    else $error("high side driven outside push-pull");

  // Peripheral input on an input pin sees the pad
  a_af_in_pin: assert property (@(posedge core_clk) disable iff (!arst_n)
    1'b1 |=> ((af_in ^ $past(pin_in)) & $past(~dir_ff & af_in_en)) == '0)
    else $error("peripheral input not fed from pin");

  // Unused peripheral inputs stay quiet
  a_af_in_masked: assert property (@(posedge core_clk) disable iff (!arst_n)
    1'b1 |=> (af_in & ~$past(af_in_en)) == '0)
    else $error("peripheral input active while unused");

  // Hidden latch: a request needs an armed pin
  a_unarmed_quiet: assert property (@(posedge core_clk) disable iff (!arst_n)
    (!grp.pend && grp.armed == '0) |=> !grp.pend)
    else $error("request raised with no armed pin");

  // Unmasked request reaches the processor a cycle later
  a_irq_delivered: assert property (@(posedge core_clk) disable iff (!arst_n)
    (grp.pend && !cpu_irq_mask) |=> ext_irq_req)
    else $error("unmasked request not delivered");

  // Wake ignores the mask so a halted core always returns
  a_wake_follows: assert property (@(posedge core_clk) disable iff (!arst_n)
    1'b1 |=> wake_req == $past(grp.pend))
    else $error("wake request does not follow latch");

  // No disable here, so the reset state itself is checked
  a_reset_floating: assert property (@(posedge core_clk)
    !arst_n |=> dir_ff == '0 && opt_ff == '0 && pin_data_latch_ff == '0 &&
                pin_oe_n == '1 && pin_pullup_en == '0)
    else $error("reset did not leave floating inputs");

endmodule

// [verification/pin_pad_model.sv]
/*
  Board-side model of the eight pads: resolves the level seen on pin_in
  from the port drive, the pull-up and external drivers on the board.
  Assumes pad controls are settled before each rising edge of core_clk.
*/
`timescale 1ns/10ps
module pin_pad_model (
  // Clock
  input  wire logic       core_clk,
  // Pad controls from the port
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] pin_pullup_en,
  // Board drivers
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  // Resolved pad level
  output logic      [7:0] pin_in
);
  logic [7:0] float_ff = 8'h55;

  // Undriven pads wander every cycle so no stale level can be trusted
  always_ff @(posedge core_clk)
    float_ff <= ~float_ff;

  // Port drive wins over the board, the board wins over the pull-up
  assign pin_in = (~pin_oe_n & pin_out)
                | (pin_oe_n & ext_en & ext_val)
                | (pin_oe_n & ~ext_en & (pin_pullup_en | float_ff));
endmodule

// [verification/parallel_io_port_with_ext_irq_tb_top.sv]
/*
  Self-checking bench of the I/O port: register access over Avalon-MM,
  pad modes, alternate functions and the external interrupt request.
  Assumes pin_pad_model stands in for the board and one 20 MHz clock.
*/
`timescale 1ns/10ps
module parallel_io_port_with_ext_irq_tb_top;
  logic        core_clk       = 1'b0;
  logic        arst_n         = 1'b0;
  logic [4:0]  avs_address    = 5'h00;
  logic        avs_read       = 1'b0;
  logic        avs_write      = 1'b0;
  logic [31:0] avs_writedata  = 32'h0;
  logic [3:0]  avs_byteenable = 4'h1;
  logic [31:0] avs_readdata, rd;
  logic        avs_waitrequest, ext_irq_req, wake_req;
  logic [7:0]  pin_in, pin_out, pin_oe_n, pin_pullup_en, af_in;
  logic [7:0]  af_out_en = 8'h00, af_out = 8'h00, af_open_drain = 8'h00, af_in_en = 8'h00;
  logic [7:0]  ext_val = 8'h00, ext_en = 8'hff;
  logic        cpu_irq_mask = 1'b0, vector_fetch = 1'b0;
  int          errors = 0, n_tests = 0, cycles = 0;
  gpio_port_pkg::sens_t order [4] = '{gpio_port_pkg::SENS_RISE, gpio_port_pkg::SENS_FALL,
                                      gpio_port_pkg::SENS_BOTH, gpio_port_pkg::SENS_FALL_LOW};

  gpio_port #(.WIDTH(8), .IRQ_PINS(8'hff)) u_dut (
    .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pullup_en),
    .af_out_en(af_out_en), .af_out(af_out), .af_open_drain(af_open_drain),
    .af_in_en(af_in_en), .af_in(af_in), .cpu_irq_mask(cpu_irq_mask),
    .vector_fetch(vector_fetch), .ext_irq_req(ext_irq_req), .wake_req(wake_req));

  pin_pad_model u_pads (
    .core_clk(core_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup_en(pin_pullup_en), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

  // 50 ns period
  always #25 core_clk = ~core_clk;

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Run is about two hundred cycles; a hang is cut well beyond that
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      $display("ERROR %0t timeout", $time);
      conclude();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Request held until waitrequest is sampled low; read data taken there
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address    <= a;
    avs_writedata  <= d;
    avs_byteenable <= be;
    avs_read       <= ~wr;
    avs_write      <= wr;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20)
      chk(1'b0, 1'b1, "waitrequest stuck");
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic fetch();
    @(posedge core_clk);
    vector_fetch <= 1'b1;
    @(posedge core_clk);
    vector_fetch <= 1'b0;
  endtask

  task automatic reset_check();
    chk(pin_oe_n, 8'hff, "oe after reset");
    chk(pin_pullup_en, 8'h00, "pullup after reset");
    bus(1'b0, gpio_port_pkg::OFS_DIR, 32'h0, 4'h1);
    chk(rd, gpio_port_pkg::RST_DIR, "dir reset");
    bus(1'b0, gpio_port_pkg::OFS_OPT, 32'h0, 4'h1);
    chk(rd, gpio_port_pkg::RST_OPT, "opt reset");
    bus(1'b0, gpio_port_pkg::OFS_SENS, 32'h0, 4'h3);
    chk(rd, gpio_port_pkg::RST_SENS, "sens reset");
    bus(1'b0, 5'h18, 32'h0, 4'h1);
    chk(rd, 32'h0, "unmapped read");
  endtask

  initial
  begin
    cyc(3);
    arst_n <= 1'b1;
    reset_check();
    $display("test reset done");
    // Output modes; latch written first so the pad starts right
    bus(1'b1, gpio_port_pkg::OFS_DATA, 32'ha5, 4'h1);
    bus(1'b1, gpio_port_pkg::OFS_OPT, 32'hff, 4'h1);
    bus(1'b1, gpio_port_pkg::OFS_DIR, 32'hff, 4'h1);
    cyc(3);
    chk(pin_oe_n, 8'h00, "push-pull drives");
    chk(pin_out, 8'ha5, "push-pull value");
    chk(pin_pullup_en, 8'h00, "no pullup on output");
    bus(1'b1, gpio_port_pkg::OFS_OPT, 32'h00, 4'h1);
    cyc(3);
    chk(pin_oe_n, 8'ha5, "open-drain ones float");
    chk(pin_out & ~pin_oe_n, 8'h00, "open-drain zeros");
    bus(1'b0, gpio_port_pkg::OFS_DATA, 32'h0, 4'h1);
    chk(rd, 8'ha5, "output reads latch");
    $display("test output done");
    // Inputs: pull-up on low nibble, board drives high nibble
    ext_val <= 8'h3c;
    ext_en  <= 8'hf0;
    bus(1'b1, gpio_port_pkg::OFS_DIR, 32'h00, 4'h1);
    bus(1'b1, gpio_port_pkg::OFS_OPT, 32'h0f, 4'h1);
    cyc(3);
    chk(pin_pullup_en, 8'h0f, "pullup inputs");
    chk(pin_oe_n, 8'hff, "inputs undriven");
    bus(1'b0, gpio_port_pkg::OFS_DATA, 32'h0, 4'h1);
    chk(rd, 8'h3f, "input reads pins");
    bus(1'b0, gpio_port_pkg::OFS_PIN, 32'h0, 4'h1);
    chk(rd, 8'h3f, "raw pin levels");
    bus(1'b1, gpio_port_pkg::OFS_DATA, 32'h5a, 4'h1);
    cyc(3);
    chk(pin_oe_n, 8'hff, "latch write leaves pads");
    bus(1'b0, gpio_port_pkg::OFS_DATA, 32'h0, 4'h1);
    chk(rd, 8'h3f, "still reads pins");
    ext_en <= 8'hff;
    bus(1'b1, gpio_port_pkg::OFS_OPT, 32'hff, 4'h1);
    bus(1'b1, gpio_port_pkg::OFS_DIR, 32'hff, 4'h1);
    cyc(3);
    chk(pin_out, 8'h5a, "hidden latch now driven");
    $display("test input done");
    // Alternate functions on floating inputs, then peripheral input on output pins
    bus(1'b1, gpio_port_pkg::OFS_DIR, 32'h00, 4'h1);
    bus(1'b1, gpio_port_pkg::OFS_OPT, 32'h00, 4'h1);
    ext_val   <= 8'h00;
    af_out_en <= 8'h01;
    af_out    <= 8'h01;
    cyc(3);
    chk(pin_oe_n[0], 1'b0, "peripheral takes pin");
    chk(pin_out[0], 1'b1, "peripheral value");
    af_open_drain <= 8'h01;
    cyc(3);
    chk(pin_oe_n[0], 1'b1, "peripheral open-drain");
    bus(1'b0, gpio_port_pkg::OFS_DATA, 32'h0, 4'h1);
    chk(rd, 8'h01, "reads peripheral output");
    af_out_en <= 8'h00;
    af_in_en  <= 8'hff;
    ext_val   <= 8'hc3;
    cyc(3);
    chk(af_in, 8'hc3, "peripheral sees pins");
    bus(1'b0, gpio_port_pkg::OFS_DATA, 32'h0, 4'h1);
    chk(rd, 8'hc3, "pins still readable");
    bus(1'b1, gpio_port_pkg::OFS_DIR, 32'hff, 4'h1);
    cyc(3);
    chk(af_in, 8'h5a, "peripheral sees latch");
    af_in_en <= 8'h00;
    $display("test alternate done");
    // Every sensitivity code on pin 0; each new code drops the old request
    ext_val <= 8'hff;
    bus(1'b1, gpio_port_pkg::OFS_DIR, 32'h00, 4'h1);
    bus(1'b1, gpio_port_pkg::OFS_OPT, 32'h03, 4'h1);
    foreach (order[i])
    begin
      bus(1'b1, gpio_port_pkg::OFS_SENS, {28'h0, order[i], order[i]}, 4'h3);
      cyc(3);
      chk(ext_irq_req, 1'b0, "sens write clears");
      ext_val <= 8'hfe;
      cyc(4);
      chk(ext_irq_req, order[i] != gpio_port_pkg::SENS_RISE, "falling");
      fetch();
      cyc(3);
      chk(ext_irq_req, order[i] == gpio_port_pkg::SENS_FALL_LOW, "fetch");
      ext_val <= 8'hff;
      cyc(4);
      chk(ext_irq_req, order[i] != gpio_port_pkg::SENS_FALL, "rising");
    end
    $display("test sensitivity done");
    // Mask, wake-up, OR of pins and an unarmed pin
    cpu_irq_mask <= 1'b1;
    bus(1'b1, gpio_port_pkg::OFS_SENS, 32'h000a, 4'h3);
    cyc(3);
    ext_val <= 8'hfd;
    cyc(4);
    chk(wake_req, 1'b1, "pin 1 wakes");
    chk(ext_irq_req, 1'b0, "masked");
    bus(1'b0, gpio_port_pkg::OFS_PEND, 32'h0, 4'h1);
    chk(rd, 32'h0, "request latch hidden");
    cpu_irq_mask <= 1'b0;
    cyc(3);
    chk(ext_irq_req, 1'b1, "unmasked");
    fetch();
    cyc(3);
    chk(wake_req, 1'b0, "fetch clears wake");
    ext_val <= 8'hf9;
    cyc(4);
    chk(ext_irq_req, 1'b0, "unarmed pin ignored");
    $display("test mask done");
    // Reset in mid-run returns every pad to floating input
    arst_n <= 1'b0;
    cyc(2);
    arst_n <= 1'b1;
    reset_check();
    chk(ext_irq_req, 1'b0, "no request after reset");
    $display("test second reset done");
    conclude();
  end
endmodule
